//--- rtl/ofrf_pkg.sv
// Purpose: constants and types for the offcore response event filter
// Assumes: filter registers sit behind the core's model-specific port
// Notes: reserved filter bits are not stored and read back as zero
package ofrf_pkg;
  localparam logic [31:0] FILT0_ADDR = 32'h0000_01A6;
  localparam logic [31:0] FILT1_ADDR = 32'h0000_01A7;
  localparam logic [7:0] EVENT_CODE = 8'hB7;
  localparam int UMASK_F0_POS = 0;
  localparam int UMASK_F1_POS = 1;

  localparam int REQ_LSB = 0;
  localparam int REQ_MSB = 15;
  localparam int SUP_LSB = 16;
  localparam int SUP_MSB = 30;
  localparam int SNP_LSB = 31;
  localparam int SNP_MSB = 37;
  localparam int OUTST_POS = 38;

  // request type positions
  localparam int REQ_DEMAND_DATA = 0;
  localparam int REQ_DEMAND_OWNERSHIP_READ = 1;
  localparam int REQ_DEMAND_CODE = 2;
  localparam int REQ_EVICTION_WRITEBACK = 3;
  localparam int REQ_L2_PREFETCH_DATA = 4;
  localparam int REQ_L2_PREFETCH_OWNERSHIP = 5;
  localparam int REQ_RESERVED = 6;
  localparam int REQ_PARTIAL_READ = 7;
  localparam int REQ_PARTIAL_WRITE = 8;
  localparam int REQ_UNCACHED_CODE_READ = 9;
  localparam int REQ_LOCKED_ACCESS = 10;
  localparam int REQ_FULL_STREAM_STORE = 11;
  localparam int REQ_SOFTWARE_PREFETCH = 12;
  localparam int REQ_L1_PREFETCH_DATA = 13;
  localparam int REQ_PARTIAL_STREAM_STORE = 14;
  localparam int REQ_ANY = 15;

  // snoop positions, relative to SNP_LSB
  localparam int RESP_TRUE_MISS = 2;
  localparam int RESP_PEER_HIT_CLEAN = 3;
  localparam int RESP_PEER_HIT_MODIFIED = 5;
  localparam int RESP_NON_MEMORY_TARGET = 6;
  // any-response position, relative to SUP_LSB
  localparam int RESP_ANY_POS = 0;

  localparam logic [15:0] REQ_VALID_MASK = 16'hFFBF;
  localparam logic [6:0] SNP_VALID_MASK = 7'h6C;
  localparam logic [14:0] SUP_VALID_MASK = 15'h7FFF;
  localparam logic [63:0] FILT0_WMASK =
    {25'h0, 1'b1, SNP_VALID_MASK, SUP_VALID_MASK, REQ_VALID_MASK};
  localparam logic [63:0] FILT1_WMASK =
    {25'h0, 1'b0, SNP_VALID_MASK, SUP_VALID_MASK, REQ_VALID_MASK};
  localparam logic [63:0] FILT_RESET = 64'h0;

  typedef struct packed {
    logic [15:0] req;
    logic l2_miss;
    logic [14:0] supply;
    logic [6:0] snoop;
  } ofrf_txn_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] umask;
  } ofrf_csel_t;
endpackage

//--- rtl/ofrf_match.sv
// Purpose: match one filter register against a transaction
// Assumes: filter value already has reserved bits cleared
// Notes: purely combinational; two copies for filter zero (enqueue and departure), one for filter one
`timescale 1ns/100ps
module ofrf_match (
  input wire logic [63:0] filt,
  input wire ofrf_pkg::ofrf_txn_t txn,
  input wire logic [15:0] q_req,
  output logic cfg_ok,
  output logic outst_mode,
  output logic hit,
  output logic q_hit
);
  logic [15:0] req_m;
  logic [14:0] sup_m;
  logic [6:0] snp_m;
  logic req_ok;
  logic resp_ok;
  logic sup_hit;
  logic snp_hit;

  assign req_m = filt[ofrf_pkg::REQ_MSB:ofrf_pkg::REQ_LSB]
    & ofrf_pkg::REQ_VALID_MASK;
  assign sup_m = filt[ofrf_pkg::SUP_MSB:ofrf_pkg::SUP_LSB];
  assign snp_m = filt[ofrf_pkg::SNP_MSB:ofrf_pkg::SNP_LSB]
    & ofrf_pkg::SNP_VALID_MASK;
  assign outst_mode = filt[ofrf_pkg::OUTST_POS];

  assign req_ok = |req_m;
  assign resp_ok = (|sup_m) | (|snp_m) | outst_mode;
  assign cfg_ok = req_ok & resp_ok;

  // any-response bit matches every completion
  assign sup_hit = sup_m[ofrf_pkg::RESP_ANY_POS]
    | (|(sup_m & txn.supply));
  // snoop qualifiers only speak for L2 misses
  assign snp_hit = txn.l2_miss & (|(snp_m & txn.snoop));

  // response bits are ignored in outstanding mode
  assign hit = cfg_ok & ~outst_mode & (|(req_m & txn.req))
    & (sup_hit | snp_hit);
  assign q_hit = cfg_ok & outst_mode & (|(req_m & q_req));
endmodule

//--- rtl/ofrf_top.sv
// Purpose: per-core offcore response filter feeding event counters
// Assumes: inputs synchronous to clk; one completion per cycle at most
// Notes: counter increments are registered, one cycle behind the event
`timescale 1ns/100ps
module ofrf_top #(
  parameter int NUM_CTR = 4,
  parameter int OQ_W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic msr_rd,
  input wire logic msr_wr,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata,
  output logic msr_ack,
  output logic msr_fault,
  input wire logic txn_valid,
  input wire ofrf_pkg::ofrf_txn_t txn,
  input wire logic oq_enq,
  input wire logic [15:0] oq_enq_req,
  input wire logic oq_deq,
  input wire logic [15:0] oq_deq_req,
  input wire ofrf_pkg::ofrf_csel_t [NUM_CTR-1:0] ctr_sel,
  output logic [NUM_CTR-1:0][OQ_W-1:0] ctr_inc,
  output logic [OQ_W-1:0] oq_count
);
  logic [63:0] filt0_q;
  logic [63:0] filt1_q;
  logic hit_f0;
  logic map_f0;
  logic map_f1;
  ofrf_pkg::ofrf_txn_t txn_n;
  logic cfg0_ok;
  logic cfg1_ok;
  logic outst0;
  logic outst1_unused;
  logic hit0;
  logic hit1;
  logic enq_hit;
  logic deq_hit;
  logic q1_unused_a;
  logic q1_unused_b;
  logic [OQ_W-1:0] oq_cnt_q;
  logic [OQ_W-1:0] oq_cnt_d;
  logic [NUM_CTR-1:0][OQ_W-1:0] inc_d;

  // every check below runs on the core clock and sleeps in reset
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  assign map_f0 = (msr_addr == ofrf_pkg::FILT0_ADDR);
  assign map_f1 = (msr_addr == ofrf_pkg::FILT1_ADDR);
  assign hit_f0 = map_f0;

  // filter registers; reserved bits never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt0_q <= ofrf_pkg::FILT_RESET;
    end else if (msr_wr && map_f0) begin
      filt0_q <= msr_wdata & ofrf_pkg::FILT0_WMASK;
    end
  end

  // filter one has no outstanding control bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt1_q <= ofrf_pkg::FILT_RESET;
    end else if (msr_wr && map_f1) begin
      filt1_q <= msr_wdata & ofrf_pkg::FILT1_WMASK;
    end
  end

  // read data and the access answer, one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msr_rdata <= 64'h0;
      msr_ack <= 1'b0;
      msr_fault <= 1'b0;
    end else begin
      msr_ack <= (msr_rd | msr_wr) & (map_f0 | map_f1);
      msr_fault <= (msr_rd | msr_wr) & ~(map_f0 | map_f1);
      if (msr_rd && hit_f0) begin
        msr_rdata <= filt0_q;
      end else if (msr_rd && map_f1) begin
        msr_rdata <= filt1_q;
      end else if (msr_rd) begin
        msr_rdata <= 64'h0;
      end
    end
  end

  // the any-request class is implied for every uncore request
  always_comb begin
    txn_n = txn;
    txn_n.req[ofrf_pkg::REQ_RESERVED] = 1'b0;
    txn_n.req[ofrf_pkg::REQ_ANY] = 1'b1;
  end
  // classes 0-5 and 7-14 pass through as reported by the caches

  ofrf_match u_match0 (
    .filt(filt0_q),
    .txn(txn_n),
    .q_req(oq_enq_req | {16'h8000}),
    .cfg_ok(cfg0_ok),
    .outst_mode(outst0),
    .hit(hit0),
    .q_hit(enq_hit)
  );

  ofrf_match u_match1 (
    .filt(filt1_q),
    .txn(txn_n),
    .q_req(16'h0),
    .cfg_ok(cfg1_ok),
    .outst_mode(outst1_unused),
    .hit(hit1),
    .q_hit(q1_unused_a)
  );

  // departure match uses filter zero against the answered request
  ofrf_match u_match0_deq (
    .filt(filt0_q),
    .txn(txn_n),
    .q_req(oq_deq_req | {16'h8000}),
    .cfg_ok(),
    .outst_mode(),
    .hit(),
    .q_hit(deq_hit)
  );
  assign q1_unused_b = q1_unused_a;

  // outstanding matching requests in the uncore request queue;
  // a mask change while requests are in flight skews the count
  always_comb begin
    oq_cnt_d = oq_cnt_q;
    if ((oq_enq && enq_hit) && !(oq_deq && deq_hit)) begin
      if (oq_cnt_q != {OQ_W{1'b1}}) begin
        oq_cnt_d = oq_cnt_q + OQ_W'(1);
      end
    end else if (!(oq_enq && enq_hit) && (oq_deq && deq_hit)) begin
      if (oq_cnt_q != '0) begin
        oq_cnt_d = oq_cnt_q - OQ_W'(1);
      end
    end
    if (!outst0) begin
      oq_cnt_d = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oq_cnt_q <= '0;
    end else begin
      oq_cnt_q <= oq_cnt_d;
    end
  end
  assign oq_count = oq_cnt_q;

  // per counter selection; union of both filters when both umasks set and filter zero is not in outstanding mode
  always_comb begin
    logic sel0;
    logic sel1;
    sel0 = 1'b0;
    sel1 = 1'b0;
    for (int i = 0; i < NUM_CTR; i++) begin
      sel0 = (ctr_sel[i].code == ofrf_pkg::EVENT_CODE)
        && ctr_sel[i].umask[ofrf_pkg::UMASK_F0_POS];
      sel1 = (ctr_sel[i].code == ofrf_pkg::EVENT_CODE)
        && ctr_sel[i].umask[ofrf_pkg::UMASK_F1_POS];
      inc_d[i] = '0;
      if (sel0 && outst0 && cfg0_ok) begin
        inc_d[i] = oq_cnt_q;
      end else if (txn_valid && ((sel0 && hit0) || (sel1 && hit1))) begin
        inc_d[i] = OQ_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctr_inc <= '0;
    end else begin
      ctr_inc <= inc_d;
    end
  end

  // checks
  logic [1:0] prev_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 2'b00;
    end else begin
      prev_q <= {q1_unused_b, cfg1_ok};
    end
  end

  // register port: storage, read back and answers
  filt1_no_outst_a: assert property (
    filt1_q[ofrf_pkg::OUTST_POS] == 1'b0)
    else $error("filter one holds an outstanding bit");

  filt1_mode_off_a: assert property (
    !outst1_unused)
    else $error("filter one entered outstanding mode");

  write_store_a: assert property (
    msr_wr && map_f0 |=> filt0_q == ($past(msr_wdata)
      & ofrf_pkg::FILT0_WMASK))
    else $error("filter zero write not stored");

  write_store1_a: assert property (
    msr_wr && map_f1 |=> filt1_q == ($past(msr_wdata)
      & ofrf_pkg::FILT1_WMASK))
    else $error("filter one write not stored");

  // a stray update would silently retarget a running counter
  filt_hold_a: assert property (
    !msr_wr |=> $stable(filt0_q) && $stable(filt1_q))
    else $error("filter changed without a write");

  resv_zero_a: assert property (
    filt0_q[ofrf_pkg::REQ_RESERVED] == 1'b0
    && filt1_q[ofrf_pkg::SNP_LSB+1:ofrf_pkg::SNP_LSB] == 2'b00)
    else $error("reserved filter bit stored");

  read_back_a: assert property (
    msr_rd && map_f1 && !msr_wr |=> msr_ack
      && msr_rdata == $past(filt1_q))
    else $error("filter one read back wrong");

  read_back0_a: assert property (
    msr_rd && map_f0 |=> msr_ack && msr_rdata == $past(filt0_q))
    else $error("filter zero read back wrong");

  rdata_hold_a: assert property (
    !msr_rd |=> $stable(msr_rdata))
    else $error("read data moved without a read");

  unmapped_a: assert property (
    (msr_rd || msr_wr) && !map_f0 && !map_f1 |=> msr_fault && !msr_ack)
    else $error("unmapped access not faulted");

  unmapped_rd_a: assert property (
    msr_rd && !map_f0 && !map_f1 |=> msr_rdata == 64'h0)
    else $error("unmapped read returned data");

  idle_quiet_a: assert property (
    !msr_rd && !msr_wr |=> !msr_ack && !msr_fault)
    else $error("answer without a request");

  ack_excl_a: assert property (
    !(msr_ack && msr_fault))
    else $error("access both answered and faulted");

  // matching and per counter increments
  txn_class_a: assert property (
    txn_n.req[ofrf_pkg::REQ_ANY] && !txn_n.req[ofrf_pkg::REQ_RESERVED])
    else $error("request class vector not normalised");

  bad_cfg_zero_a: assert property (
    !cfg0_ok && !cfg1_ok |=> ctr_inc == '0)
    else $error("count with invalid filters");

  no_req_zero_a: assert property (
    filt0_q[15:0] == 16'h0 |-> !cfg0_ok && !hit0)
    else $error("empty request mask accepted");

  no_req1_zero_a: assert property (
    filt1_q[15:0] == 16'h0 |-> !cfg1_ok && !hit1)
    else $error("empty request mask accepted on filter one");

  resp_valid_a: assert property (
    cfg1_ok |-> (filt1_q[ofrf_pkg::SNP_MSB:ofrf_pkg::SUP_LSB] != 22'h0))
    else $error("response pattern not required");

  snoop_miss_only_a: assert property (
    !txn.l2_miss && filt0_q[ofrf_pkg::SUP_MSB:ofrf_pkg::SUP_LSB] == 15'h0
    |-> !hit0)
    else $error("snoop qualifier matched an L2 hit");

  single_count_a: assert property (
    txn_valid && hit1 && !outst0 && ctr_sel[1].code == ofrf_pkg::EVENT_CODE
    && ctr_sel[1].umask[ofrf_pkg::UMASK_F1_POS] |=> ctr_inc[1] == OQ_W'(1))
    else $error("matching completion not counted once");

  f0_count_a: assert property (
    txn_valid && hit0 && !outst0 && ctr_sel[0].code == ofrf_pkg::EVENT_CODE
    && ctr_sel[0].umask[ofrf_pkg::UMASK_F0_POS] |=> ctr_inc[0] == OQ_W'(1))
    else $error("filter zero completion not counted once");

  // outside the weighted mode only a matching completion may count
  no_event_zero_a: assert property (
    !outst0 && !(txn_valid && (hit0 || hit1)) |=> ctr_inc == '0)
    else $error("counter moved without a matching completion");

  other_event_a: assert property (
    ctr_sel[NUM_CTR-1].code != ofrf_pkg::EVENT_CODE
    |=> ctr_inc[NUM_CTR-1] == '0)
    else $error("counter moved on another event");

  // outstanding mode
  weighted_a: assert property (
    outst0 && cfg0_ok && ctr_sel[0].code == ofrf_pkg::EVENT_CODE
    && ctr_sel[0].umask[ofrf_pkg::UMASK_F0_POS] |=> ctr_inc[0]
      == $past(oq_cnt_q))
    else $error("weighted cycles wrong");

  oq_step_a: assert property (
    outst0 && oq_enq && enq_hit && !oq_deq && oq_cnt_q < OQ_W'(8)
    ##1 outst0 |-> oq_cnt_q == $past(oq_cnt_q) + OQ_W'(1))
    else $error("outstanding count did not rise");

  oq_fall_a: assert property (
    outst0 && oq_deq && deq_hit && !(oq_enq && enq_hit)
    && oq_cnt_q != '0
    ##1 outst0 |-> oq_cnt_q == $past(oq_cnt_q) - OQ_W'(1))
    else $error("outstanding count did not fall");

  // unselected queue traffic must not leak into the weight
  oq_idle_a: assert property (
    !(oq_enq && enq_hit) && !(oq_deq && deq_hit)
    |=> oq_cnt_q == $past(oq_cnt_q) || oq_cnt_q == '0)
    else $error("outstanding count moved without traffic");

  outst_no_hit_a: assert property (
    outst0 |-> !hit0)
    else $error("completion matched in outstanding mode");

  outst_clear_a: assert property (
    !outst0 [*2] |-> oq_cnt_q == '0)
    else $error("outstanding count kept outside mode");

  // main scenarios
  snoop_hit_c: cover property (
    txn_valid && txn.l2_miss && hit0);
  outst_run_c: cover property (
    outst0 && oq_cnt_q > OQ_W'(1) ##[1:20] oq_cnt_q == '0);
  two_ctr_c: cover property (
    ctr_inc[0] > OQ_W'(1) && ctr_inc[1] == OQ_W'(1));
  union_c: cover property (
    txn_valid && hit0 && hit1 && prev_q != 2'b11);
endmodule

//--- verif/ofrf_far.sv
// Purpose: stand-in for the core caches and the uncore request queue
// Assumes: one completion or queue event per call, one cycle each
// Notes: released data lines show the inverse of the last value; strobes drop low
`timescale 1ns/100ps
module ofrf_far (
  input wire logic clk,
  output logic txn_valid,
  output ofrf_pkg::ofrf_txn_t txn,
  output logic oq_enq,
  output logic [15:0] oq_enq_req,
  output logic oq_deq,
  output logic [15:0] oq_deq_req
);
  initial begin
    txn_valid = 1'b0;
    txn = '0;
    oq_enq = 1'b0;
    oq_deq = 1'b0;
    oq_enq_req = 16'h0;
    oq_deq_req = 16'h0;
  end

  task automatic complete(input logic [15:0] r, input logic m,
      input logic [6:0] s);
    @(posedge clk);
    txn_valid <= 1'b1;
    txn <= {r, m, 15'h0, s};
    @(posedge clk);
    txn_valid <= 1'b0;
    txn <= ~txn;
  endtask

  // enq high enters the queue, low returns a response
  task automatic queue_evt(input logic enq, input logic [15:0] r);
    @(posedge clk);
    oq_enq <= enq;
    oq_deq <= ~enq;
    oq_enq_req <= r;
    oq_deq_req <= r;
    @(posedge clk);
    oq_enq <= 1'b0;
    oq_deq <= 1'b0;
    oq_enq_req <= ~r;
    oq_deq_req <= ~r;
  endtask
endmodule

//--- verif/tb_top.sv
// Purpose: self-checking bench for the offcore response filter
// Assumes: counters 0-2 take the event with umask 01, 02, 03
// Notes: counter 3 selects another code and must stay idle
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic msr_rd = 1'b0;
  logic msr_wr = 1'b0;
  logic [31:0] msr_addr = 32'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic [63:0] msr_rdata;
  logic msr_ack;
  logic msr_fault;
  logic txn_valid;
  ofrf_pkg::ofrf_txn_t txn;
  logic oq_enq;
  logic oq_deq;
  logic [15:0] oq_enq_req;
  logic [15:0] oq_deq_req;
  ofrf_pkg::ofrf_csel_t [3:0] ctr_sel;
  logic [3:0][5:0] ctr_inc;
  logic [5:0] oq_count;
  int err_total = 0;
  int check_count = 0;

  always #5 clk = ~clk;
  assign ctr_sel = {8'hB6, 8'h01, ofrf_pkg::EVENT_CODE, 8'h03,
    ofrf_pkg::EVENT_CODE, 8'h02, ofrf_pkg::EVENT_CODE, 8'h01};

  ofrf_top #(.NUM_CTR(4), .OQ_W(6)) ofrf_top_inst (.clk(clk),
    .sys_rst(sys_rst), .msr_rd(msr_rd), .msr_wr(msr_wr),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .msr_ack(msr_ack), .msr_fault(msr_fault), .txn_valid(txn_valid),
    .txn(txn), .oq_enq(oq_enq), .oq_enq_req(oq_enq_req),
    .oq_deq(oq_deq), .oq_deq_req(oq_deq_req), .ctr_sel(ctr_sel),
    .ctr_inc(ctr_inc), .oq_count(oq_count));

  ofrf_far ofrf_far_inst (.clk(clk), .txn_valid(txn_valid), .txn(txn),
    .oq_enq(oq_enq), .oq_enq_req(oq_enq_req), .oq_deq(oq_deq),
    .oq_deq_req(oq_deq_req));

  function automatic logic [63:0] b(input int p);
    return 64'h1 << p;
  endfunction

  function automatic logic [31:0] fa(input logic one);
    return one ? ofrf_pkg::FILT1_ADDR : ofrf_pkg::FILT0_ADDR;
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request cycle, then a bounded wait for ack or fault
  task automatic acc(input logic wr, input logic [31:0] a,
      input logic [63:0] d, input logic [63:0] ex, input logic xf);
    int n;
    n = 0;
    @(posedge clk);
    msr_wr <= wr;
    msr_rd <= ~wr;
    msr_addr <= a;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr <= 1'b0;
    msr_rd <= 1'b0;
    @(negedge clk);
    while (msr_ack !== 1'b1 && msr_fault !== 1'b1) begin
      n++;
      if (n > 4) begin
        chk("register answer", 64'h1, 64'h0);
        final_report();
      end
      @(negedge clk);
    end
    chk("msr_fault", 64'(xf), 64'(msr_fault));
    chk("msr_ack", 64'(!xf), 64'(msr_ack));
    if (!wr) chk("msr_rdata", ex, msr_rdata);
  endtask

  task automatic wf(input logic one, input logic [63:0] d);
    acc(1'b1, fa(one), d, 64'h0, 1'b0);
  endtask

  task automatic rd(input logic one, input logic [63:0] ex);
    acc(1'b0, fa(one), 64'h0, ex, 1'b0);
  endtask

  // e holds the expected one-cycle increment of each counter
  task automatic ev(input logic [15:0] r, input logic m,
      input logic [6:0] s, input logic [3:0] e);
    logic [63:0] x;
    x = 64'h0;
    for (int i = 0; i < 4; i++) x[i*6] = e[i];
    ofrf_far_inst.complete(r, m, s);
    @(negedge clk);
    chk("ctr_inc", x, 64'(ctr_inc));
    @(negedge clk);
    chk("ctr_inc idle", 64'h0, 64'(ctr_inc));
  endtask

  task automatic t_regs;
    rd(1'b0, ofrf_pkg::FILT_RESET);
    rd(1'b1, ofrf_pkg::FILT_RESET);
    wf(1'b0, '1);
    rd(1'b0, ofrf_pkg::FILT0_WMASK);
    wf(1'b1, '1);
    rd(1'b1, ofrf_pkg::FILT1_WMASK);
    acc(1'b1, 32'h0000_01A8, '1, 64'h0, 1'b1);
    acc(1'b0, 32'h0000_01A8, 64'h0, 64'h0, 1'b1);
    $display("test regs done");
  endtask

  task automatic t_req;
    wf(1'b1, 64'h0);
    for (int p = 0; p < 15; p++) begin
      if (p != 6) begin
        wf(1'b0, b(p) | b(16));
        ev(16'(b(p)), 1'b0, 7'h0, 4'h5);
        ev(16'(b(p == 0 ? 1 : 0)), 1'b0, 7'h0, 4'h0);
      end
    end
    wf(1'b0, b(15) | b(16));
    ev(16'h0008, 1'b0, 7'h0, 4'h5);
    $display("test req done");
  endtask

  task automatic t_snoop;
    int s[4] = '{33, 34, 36, 37};
    foreach (s[k]) begin
      wf(1'b0, b(15) | b(s[k]));
      ev(16'h0001, 1'b1, 7'(b(s[k] - 31)), 4'h5);
      ev(16'h0001, 1'b0, 7'(b(s[k] - 31)), 4'h0);
    end
    $display("test snoop done");
  endtask

  task automatic t_union;
    wf(1'b0, b(0) | b(16));
    wf(1'b1, b(1) | b(16));
    ev(16'h0001, 1'b0, 7'h0, 4'h5);
    ev(16'h0002, 1'b0, 7'h0, 4'h6);
    ev(16'h0003, 1'b0, 7'h0, 4'h7);
    ev(16'h0008, 1'b0, 7'h0, 4'h0);
    wf(1'b0, b(15));
    wf(1'b1, b(16));
    ev(16'h0001, 1'b0, 7'h0, 4'h0);
    $display("test union done");
  endtask

  task automatic t_outst;
    wf(1'b1, 64'h0);
    wf(1'b0, b(0) | b(38));
    ofrf_far_inst.queue_evt(1'b1, 16'h0001);
    ofrf_far_inst.queue_evt(1'b1, 16'h0001);
    @(negedge clk);
    chk("oq_count", 64'd2, 64'(oq_count));
    ofrf_far_inst.complete(16'h0001, 1'b0, 7'h0);
    @(negedge clk);
    chk("ctr_inc 0", 64'd2, 64'(ctr_inc[0]));
    chk("ctr_inc 2", 64'd2, 64'(ctr_inc[2]));
    chk("ctr_inc 1", 64'd0, 64'(ctr_inc[1]));
    ofrf_far_inst.queue_evt(1'b0, 16'h0002);
    ofrf_far_inst.queue_evt(1'b0, 16'h0001);
    @(negedge clk);
    chk("oq_count", 64'd1, 64'(oq_count));
    wf(1'b0, 64'h0);
    @(negedge clk);
    chk("oq_count", 64'd0, 64'(oq_count));
    $display("test outstanding done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_req();
    t_snoop();
    t_union();
    t_outst();
    final_report();
  end
endmodule
